// ---- logic/pdr_pkg.sv ----
// package for the peripheral dma channel register block
// assumes a 32-bit avalon-mm slave with byte addresses
package pdr_pkg;
  localparam logic [9:0] OFS_RX_PTR   = 10'h100;
  localparam logic [9:0] OFS_RX_CNT   = 10'h104;
  localparam logic [9:0] OFS_TX_PTR   = 10'h108;
  localparam logic [9:0] OFS_TX_CNT   = 10'h10C;
  localparam logic [9:0] OFS_RX_NPTR  = 10'h110;
  localparam logic [9:0] OFS_RX_NCNT  = 10'h114;
  localparam logic [9:0] OFS_TX_NPTR  = 10'h118;
  localparam logic [9:0] OFS_TX_NCNT  = 10'h11C;
  localparam logic [9:0] OFS_CTRL     = 10'h120;
  localparam logic [9:0] OFS_STATE    = 10'h124;
  localparam logic [9:0] OFS_IRQ_STAT = 10'h130;
  localparam logic [9:0] OFS_IRQ_CLR  = 10'h134;
  localparam logic [9:0] OFS_IRQ_EN   = 10'h138;
  localparam int BIT_RX_ON  = 0;
  localparam int BIT_RX_OFF = 1;
  localparam int BIT_TX_ON  = 8;
  localparam int BIT_TX_OFF = 9;
  localparam int EV_RX_DONE = 0;
  localparam int EV_RX_FULL = 1;
  localparam int EV_TX_DONE = 2;
  localparam int EV_TX_EMPT = 3;
  localparam logic [31:0] PTR_RST = 32'h0000_0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {PDR_BYTE, PDR_HALF, PDR_WORD} pdr_size_t;
  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] size;
    logic [31:0] nxt_addr;
    logic [15:0] nxt_size;
  } pdr_chan_t;
  typedef struct packed {
    pdr_chan_t   rx;
    pdr_chan_t   tx;
    logic        rx_on;
    logic        tx_on;
    logic [3:0]  ev;
    logic [3:0]  ev_en;
    logic [31:0] rdata;
    logic        rvalid;
    logic        irq;
    logic        rx_done_o;
    logic        tx_done_o;
  } pdr_state_t;
endpackage : pdr_pkg

// ---- logic/pdr_regs.sv ----
// register block of one peripheral dma channel pair
// assumes the served peripheral pulses item strobes and reads ptr/cnt live
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module pdr_regs #(
  parameter bit HALF_DUPLEX = 1'b0
) (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [9:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              rx_item_i,
  input  wire logic              tx_item_i,
  input  wire pdr_pkg::pdr_size_t item_size_i,
  output logic                   rx_requests_on_o,
  output logic                   tx_requests_on_o,
  output logic [31:0]            rx_buf_addr_o,
  output logic [31:0]            tx_buf_addr_o,
  output logic                   rx_block_done_o,
  output logic                   tx_block_done_o,
  output logic                   irq_o
);
  pdr_pkg::pdr_state_t st_ff;
  pdr_pkg::pdr_state_t nxt_st;

  function automatic logic [31:0] step_of(input pdr_pkg::pdr_size_t s);
    case (s)
      pdr_pkg::PDR_BYTE: step_of = 32'h0000_0001;
      pdr_pkg::PDR_HALF: step_of = 32'h0000_0002;
      default:           step_of = 32'h0000_0004;
    endcase
  endfunction

  function automatic logic hit(input logic [9:0] ofs);
    hit = (avs_address_i == ofs);
  endfunction

  // one item on a channel; reload from the next pair on reaching zero unless the next count is zero
  function automatic pdr_pkg::pdr_chan_t advance(input pdr_pkg::pdr_chan_t c,
                                                 input logic [31:0] step);
    pdr_pkg::pdr_chan_t r;
    r = c;
    r.addr = c.addr + step;
    r.size = c.size - 16'h0001;
    if (r.size == pdr_pkg::CNT_RST && c.nxt_size != pdr_pkg::CNT_RST) begin
      r.addr     = c.nxt_addr;
      r.size     = c.nxt_size;
      r.nxt_addr = pdr_pkg::PTR_RST;
      r.nxt_size = pdr_pkg::CNT_RST;
    end
    advance = r;
  endfunction

  logic        wr;
  logic        rd;
  logic [31:0] wd;
  logic        rx_go;
  logic        tx_go;
  logic [3:0]  set_ev;
  logic [3:0]  clr_ev;
  logic        rx_wr_nz;
  logic        tx_wr_nz;
  logic [31:0] step;
  logic [31:0] rmux;

  assign wr   = avs_write_i && !avs_read_i;
  assign rd   = avs_read_i && !st_ff.rvalid;
  assign wd   = avs_writedata_i;
  assign step = step_of(item_size_i);
  // zero count halts movement regardless of enable
  assign rx_go = rx_item_i && st_ff.rx_on && st_ff.rx.size != pdr_pkg::CNT_RST;
  // half duplex counts in the shared rx copy, so the tx copy must not gate it
  assign tx_go = tx_item_i && st_ff.tx_on &&
                 (HALF_DUPLEX ? st_ff.rx.size : st_ff.tx.size) != pdr_pkg::CNT_RST;

  always_comb begin
    rmux = pdr_pkg::RD_ZERO;
    if (hit(pdr_pkg::OFS_RX_PTR)) begin
      rmux = st_ff.rx.addr;
    end else if (hit(pdr_pkg::OFS_RX_CNT)) begin
      rmux = {16'h0000, st_ff.rx.size};
    end else if (hit(pdr_pkg::OFS_TX_PTR)) begin
      rmux = HALF_DUPLEX ? st_ff.rx.addr : st_ff.tx.addr;
    end else if (hit(pdr_pkg::OFS_TX_CNT)) begin
      rmux = {16'h0000, HALF_DUPLEX ? st_ff.rx.size : st_ff.tx.size};
    end else if (hit(pdr_pkg::OFS_RX_NPTR)) begin
      rmux = st_ff.rx.nxt_addr;
    end else if (hit(pdr_pkg::OFS_RX_NCNT)) begin
      rmux = {16'h0000, st_ff.rx.nxt_size};
    end else if (hit(pdr_pkg::OFS_TX_NPTR)) begin
      rmux = HALF_DUPLEX ? st_ff.rx.nxt_addr : st_ff.tx.nxt_addr;
    end else if (hit(pdr_pkg::OFS_TX_NCNT)) begin
      rmux = {16'h0000, HALF_DUPLEX ? st_ff.rx.nxt_size : st_ff.tx.nxt_size};
    end else if (hit(pdr_pkg::OFS_STATE)) begin
      rmux[pdr_pkg::BIT_RX_ON] = st_ff.rx_on;
      rmux[pdr_pkg::BIT_TX_ON] = st_ff.tx_on;
    end else if (hit(pdr_pkg::OFS_IRQ_STAT)) begin
      rmux[3:0] = st_ff.ev;
    end else if (hit(pdr_pkg::OFS_IRQ_EN)) begin
      rmux[3:0] = st_ff.ev_en;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    set_ev = 4'h0;
    clr_ev = 4'h0;
    rx_wr_nz = 1'b0;
    tx_wr_nz = 1'b0;
    nxt_st.rx_done_o = 1'b0;
    nxt_st.tx_done_o = 1'b0;
    nxt_st.rvalid = rd;
    if (rd) begin
      nxt_st.rdata = rmux;
    end
    // half duplex keeps everything in the rx copy; tx copy unused then
    if (rx_go) begin
      nxt_st.rx = advance(st_ff.rx, step);
      if (st_ff.rx.size == 16'h0001) begin
        set_ev[pdr_pkg::EV_RX_DONE] = 1'b1;
        set_ev[pdr_pkg::EV_RX_FULL] = (st_ff.rx.nxt_size == pdr_pkg::CNT_RST);
        nxt_st.rx_done_o = 1'b1;
      end
    end
    if (tx_go && !HALF_DUPLEX) begin
      nxt_st.tx = advance(st_ff.tx, step);
    end else if (tx_go) begin
      nxt_st.rx = advance(st_ff.rx, step);
    end
    if (tx_go) begin
      if ((HALF_DUPLEX ? st_ff.rx.size : st_ff.tx.size) == 16'h0001) begin
        set_ev[pdr_pkg::EV_TX_DONE] = 1'b1;
        set_ev[pdr_pkg::EV_TX_EMPT] =
          ((HALF_DUPLEX ? st_ff.rx.nxt_size : st_ff.tx.nxt_size) == pdr_pkg::CNT_RST);
        nxt_st.tx_done_o = 1'b1;
      end
    end
    // a software write wins over a concurrent item update of the same field
    if (wr) begin
      if (hit(pdr_pkg::OFS_RX_PTR) || (HALF_DUPLEX && hit(pdr_pkg::OFS_TX_PTR))) begin
        nxt_st.rx.addr = wd;
      end else if (hit(pdr_pkg::OFS_TX_PTR)) begin
        nxt_st.tx.addr = wd;
      end else if (hit(pdr_pkg::OFS_RX_CNT) || (HALF_DUPLEX && hit(pdr_pkg::OFS_TX_CNT))) begin
        nxt_st.rx.size = wd[15:0];
        rx_wr_nz = wd[15:0] != pdr_pkg::CNT_RST;
      end else if (hit(pdr_pkg::OFS_TX_CNT)) begin
        nxt_st.tx.size = wd[15:0];
        tx_wr_nz = wd[15:0] != pdr_pkg::CNT_RST;
      end else if (hit(pdr_pkg::OFS_RX_NPTR) || (HALF_DUPLEX && hit(pdr_pkg::OFS_TX_NPTR))) begin
        nxt_st.rx.nxt_addr = wd;
      end else if (hit(pdr_pkg::OFS_TX_NPTR)) begin
        nxt_st.tx.nxt_addr = wd;
      end else if (hit(pdr_pkg::OFS_RX_NCNT) || (HALF_DUPLEX && hit(pdr_pkg::OFS_TX_NCNT))) begin
        nxt_st.rx.nxt_size = wd[15:0];
        rx_wr_nz = wd[15:0] != pdr_pkg::CNT_RST;
      end else if (hit(pdr_pkg::OFS_TX_NCNT)) begin
        nxt_st.tx.nxt_size = wd[15:0];
        tx_wr_nz = wd[15:0] != pdr_pkg::CNT_RST;
      end else if (hit(pdr_pkg::OFS_CTRL)) begin
        if (HALF_DUPLEX) begin
          // either disable stops both; rx enable beats tx enable
          if (wd[pdr_pkg::BIT_RX_OFF] || wd[pdr_pkg::BIT_TX_OFF]) begin
            nxt_st.rx_on = 1'b0;
            nxt_st.tx_on = 1'b0;
          end else if (wd[pdr_pkg::BIT_RX_ON]) begin
            nxt_st.rx_on = 1'b1;
            nxt_st.tx_on = 1'b0;
          end else if (wd[pdr_pkg::BIT_TX_ON]) begin
            nxt_st.tx_on = 1'b1;
            nxt_st.rx_on = 1'b0;
          end
        end else begin
          if (wd[pdr_pkg::BIT_RX_OFF]) begin
            nxt_st.rx_on = 1'b0;
          end else if (wd[pdr_pkg::BIT_RX_ON]) begin
            nxt_st.rx_on = 1'b1;
          end
          if (wd[pdr_pkg::BIT_TX_OFF]) begin
            nxt_st.tx_on = 1'b0;
          end else if (wd[pdr_pkg::BIT_TX_ON]) begin
            nxt_st.tx_on = 1'b1;
          end
        end
      end else if (hit(pdr_pkg::OFS_IRQ_CLR)) begin
        clr_ev = wd[3:0];
      end else if (hit(pdr_pkg::OFS_IRQ_EN)) begin
        nxt_st.ev_en = wd[3:0];
      end
    end
    // half duplex: a nonzero count write clears both directions' flags
    if (HALF_DUPLEX && (rx_wr_nz || tx_wr_nz)) begin
      rx_wr_nz = 1'b1;
      tx_wr_nz = 1'b1;
    end
    if (rx_wr_nz) begin
      clr_ev[pdr_pkg::EV_RX_DONE] = 1'b1;
      clr_ev[pdr_pkg::EV_RX_FULL] = 1'b1;
    end
    if (tx_wr_nz) begin
      clr_ev[pdr_pkg::EV_TX_DONE] = 1'b1;
      clr_ev[pdr_pkg::EV_TX_EMPT] = 1'b1;
    end
    nxt_st.ev  = (st_ff.ev & ~clr_ev) | set_ev; // set wins over clear
    nxt_st.irq = |(nxt_st.ev & nxt_st.ev_en);
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // read answers one cycle after it is taken; writes never wait
  assign avs_waitrequest_o = avs_read_i && !st_ff.rvalid;
  assign avs_readdata_o    = st_ff.rdata;
  assign rx_requests_on_o  = st_ff.rx_on;
  assign tx_requests_on_o  = st_ff.tx_on;
  assign rx_buf_addr_o     = st_ff.rx.addr;
  assign tx_buf_addr_o     = HALF_DUPLEX ? st_ff.rx.addr : st_ff.tx.addr;
  assign rx_block_done_o   = st_ff.rx_done_o;
  assign tx_block_done_o   = st_ff.tx_done_o;
  assign irq_o             = st_ff.irq;
endmodule // pdr_regs
`default_nettype wire

// ---- verif/pdr_regs_bench.sv ----
// self-checking bench for pdr_regs with a peripheral stand-in
// assumes the designer's one-wait read and zero-wait write
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module pdr_regs_bench;
  typedef struct {logic [9:0] a; logic [31:0] w; logic [31:0] e;} pdr_row_t;
  logic clk_i = 1'b0;
  logic rst_b_i, avs_read_i, avs_write_i, go, dir, busy, rx_item_i, tx_item_i;
  logic avs_waitrequest_o, rx_requests_on_o, tx_requests_on_o;
  logic rx_block_done_o, tx_block_done_o, irq_o;
  logic [9:0]  avs_address_i, base;
  logic [3:0]  avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rx_buf_addr_o, tx_buf_addr_o, rd_v, on, step;
  pdr_pkg::pdr_size_t item_size_i;
  pdr_pkg::pdr_size_t sz[3] = '{pdr_pkg::PDR_WORD, pdr_pkg::PDR_BYTE, pdr_pkg::PDR_HALF};
  int failures = 0;
  int checked = 0;
  int k;
  int dn_rx = 0;
  int dn_tx = 0;
  int dn0;
  always @(posedge clk_i) begin
    if (rx_block_done_o === 1'b1) dn_rx++;
    if (tx_block_done_o === 1'b1) dn_tx++;
  end
  pdr_row_t rows[11] = '{'{10'h100, 32'hA5A5_0003, 32'hA5A5_0003},
    '{10'h104, 32'hFFFF_1234, 32'h0000_1234}, '{10'h108, 32'h0123_4567, 32'h0123_4567},
    '{10'h10C, 32'h8000_0001, 32'h0000_0001}, '{10'h110, 32'hFFFF_FFFC, 32'hFFFF_FFFC},
    '{10'h114, 32'h0001_FFFF, 32'h0000_FFFF}, '{10'h118, 32'h7654_3210, 32'h7654_3210},
    '{10'h11C, 32'hABCD_8000, 32'h0000_8000}, '{10'h120, 32'h0000_0000, 32'h0000_0000},
    '{10'h124, 32'hFFFF_FFFF, 32'h0000_0000}, '{10'h128, 32'hFFFF_FFFF, 32'h0000_0000}};
  pdr_regs dut (.clk_i, .rst_b_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .rx_item_i,
    .tx_item_i, .item_size_i, .rx_requests_on_o, .tx_requests_on_o, .rx_buf_addr_o,
    .tx_buf_addr_o, .rx_block_done_o, .tx_block_done_o, .irq_o);
  pdr_served_peripheral_prefix_model peer (.clk_i, .rst_b_i, .go_i(go), .dir_i(dir), .num_i(4'h4),
    .rx_item_o(rx_item_i), .tx_item_o(tx_item_i), .busy_o(busy));
  initial forever #2.5 clk_i = ~clk_i;
  // one bus cycle; entered just after a rising edge, leaves just after one
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    logic w;
    int n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_i);
      w = avs_waitrequest_o;
      rd_v = avs_readdata_o;
    end while (w && n++ < 20);
    if (w) failures++;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic close_out();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(5 * 20000);
    failures++;
    close_out();
  end
  initial begin
    {rst_b_i, avs_read_i, avs_write_i, go, dir} = 5'h00;
    {avs_address_i, avs_writedata_i} = 42'h0;
    avs_byteenable_i = 4'hF;
    item_size_i = pdr_pkg::PDR_WORD;
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, 10'h100 + 10'(4 * i), 32'h0);
      `CHK(rd_v, 32'h0)
    end
    $display("reset values done");
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a, 32'h0);
      `CHK(rd_v, rows[i].e)
    end
    $display("register table done");
    // two buffers, then one surplus strobe that must be ignored
    for (int d = 0; d < 3; d++) begin
      base = (d == 1) ? pdr_pkg::OFS_TX_PTR : pdr_pkg::OFS_RX_PTR;
      on = (d == 1) ? 32'h100 : 32'h1;
      step = (d == 0) ? 32'h4 : ((d == 1) ? 32'h1 : 32'h2);
      item_size_i <= sz[d];
      bus(1'b1, base, 32'h1000);
      bus(1'b1, base + 10'h4, 32'h2);
      bus(1'b1, base + 10'h10, 32'h2000);
      bus(1'b1, base + 10'h14, 32'h1);
      bus(1'b1, pdr_pkg::OFS_IRQ_EN, 32'hF);
      bus(1'b1, pdr_pkg::OFS_CTRL, on);
      bus(1'b0, pdr_pkg::OFS_STATE, 32'h0);
      `CHK(rd_v, on)
      `CHK((d == 1) ? tx_requests_on_o : rx_requests_on_o, 1'b1)
      dn0 = (d == 1) ? dn_tx : dn_rx;
      go <= 1'b1;
      dir <= (d == 1);
      @(posedge clk_i);
      go <= 1'b0;
      k = 0;
      do @(negedge clk_i); while (busy && k++ < 40);
      if (busy) failures++;
      `CHK((d == 1) ? tx_buf_addr_o : rx_buf_addr_o, 32'h2000 + step)
      `CHK(irq_o, 1'b1)
      @(posedge clk_i);
      bus(1'b0, base, 32'h0);
      `CHK(((d == 1) ? dn_tx : dn_rx) - dn0, 2)
      `CHK(rd_v, 32'h2000 + step)
      bus(1'b0, base + 10'h4, 32'h0);
      `CHK(rd_v, 32'h0)
      bus(1'b0, base + 10'h14, 32'h0);
      `CHK(rd_v, 32'h0)
      bus(1'b0, pdr_pkg::OFS_IRQ_STAT, 32'h0);
      `CHK(rd_v, (d == 1) ? 32'hC : 32'h3)
      bus(1'b1, pdr_pkg::OFS_IRQ_EN, 32'h0);
      @(negedge clk_i);
      `CHK(irq_o, 1'b0)
      @(posedge clk_i);
      if (d == 1) bus(1'b1, pdr_pkg::OFS_IRQ_CLR, 32'hF);
      else bus(1'b1, base + 10'h4, 32'h5);
      bus(1'b0, pdr_pkg::OFS_IRQ_STAT, 32'h0);
      `CHK(rd_v, 32'h0)
      bus(1'b1, base + 10'h4, 32'h0);
      bus(1'b1, pdr_pkg::OFS_CTRL, on << 1);
      bus(1'b0, pdr_pkg::OFS_STATE, 32'h0);
      `CHK(rd_v, 32'h0)
      $display("transfer pass %0d done", d);
    end
    // mid-run reset must wipe the live rx pointer; irq enables were already written zero before it
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    bus(1'b0, pdr_pkg::OFS_RX_PTR, 32'h0);
    `CHK(rd_v, 32'h0)
    bus(1'b0, pdr_pkg::OFS_IRQ_EN, 32'h0);
    `CHK(rd_v, 32'h0)
    $display("mid-run reset done");
    close_out();
  end
endmodule // pdr_regs_bench
`default_nettype wire

// ---- verif/pdr_regs_chk.sv ----
// checker for pdr_regs: bus handshake and strobe relations
// assumes bind to pdr_regs with half duplex off
`timescale 1ns/10ps
`default_nettype none
module pdr_regs_chk (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        rx_item_i,
  input wire logic        tx_item_i,
  input wire logic        rx_requests_on_o,
  input wire logic        tx_requests_on_o,
  input wire logic [31:0] rx_buf_addr_o,
  input wire logic [31:0] tx_buf_addr_o,
  input wire logic        rx_block_done_o,
  input wire logic        tx_block_done_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_rd_first_wait: assert property ($rose(avs_read_i) |-> avs_waitrequest_o)
    else $error("read not stalled");
  a_rd_answer: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("read answer late");
  a_wr_no_wait: assert property (avs_write_i |-> !avs_waitrequest_o)
    else $error("write stalled");
  a_idle_no_wait: assert property (!avs_read_i |-> !avs_waitrequest_o)
    else $error("stall without read");
  a_rx_done_cause: assert property (rx_block_done_o |-> $past(rx_item_i && rx_requests_on_o))
    else $error("rx done without item");
  a_tx_done_cause: assert property (tx_block_done_o |-> $past(tx_item_i && tx_requests_on_o))
    else $error("tx done without item");
  a_rx_off_hold: assert property (!rx_requests_on_o && !avs_write_i |=> $stable(rx_buf_addr_o))
    else $error("rx pointer moved while off");
  a_tx_off_hold: assert property (!tx_requests_on_o && !avs_write_i |=> $stable(tx_buf_addr_o))
    else $error("tx pointer moved while off");
  a_irq_drop: assert property ($fell(irq_o) |-> $past(avs_write_i) || $past(avs_write_i, 2))
    else $error("irq fell without write");
  c_rx_done: cover property (rx_block_done_o);
  c_tx_done: cover property (tx_block_done_o);
  c_irq: cover property ($rose(irq_o));
endmodule // pdr_regs_chk
bind pdr_regs pdr_regs_chk u_chk (.clk_i, .rst_b_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .rx_item_i, .tx_item_i, .rx_requests_on_o, .tx_requests_on_o,
  .rx_buf_addr_o, .tx_buf_addr_o, .rx_block_done_o, .tx_block_done_o, .irq_o);
`default_nettype wire

// ---- verif/pdr_served_peripheral_prefix_model.sv ----
// serial peripheral stand-in: raises one item strobe every other cycle
// assumes a one-cycle go pulse; dir 0 receive, 1 transmit
`timescale 1ns/10ps
`default_nettype none
module pdr_served_peripheral_prefix_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       go_i,
  input  wire logic       dir_i,
  input  wire logic [3:0] num_i,
  output logic            rx_item_o,
  output logic            tx_item_o,
  output logic            busy_o
);
  logic [3:0] left_ff;
  logic       ph_ff;
  logic       dir_ff;
  // spaced strobes keep each done pulse isolated
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      left_ff <= 4'h0;
      ph_ff   <= 1'b0;
      dir_ff  <= 1'b0;
    end else if (go_i) begin
      left_ff <= num_i;
      ph_ff   <= 1'b0;
      dir_ff  <= dir_i;
    end else if (left_ff != 4'h0) begin
      ph_ff <= ~ph_ff;
      if (ph_ff) left_ff <= left_ff - 4'h1;
    end
  end
  assign rx_item_o = ph_ff && !dir_ff;
  assign tx_item_o = ph_ff && dir_ff;
  assign busy_o    = left_ff != 4'h0;
endmodule // pdr_served_peripheral_prefix_model
`default_nettype wire
